// ==== core/bbs_fade_pwm.sv ====
// Triangle-wave brightness PWM used for the suspend fade
`timescale 1ns/1ps
module bbs_fade_pwm #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned STEP_CYCLES = 4096
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic enable,
  output logic pwm_out
);
  initial begin
    if (WIDTH < 2 || WIDTH > 16 || STEP_CYCLES < 1) begin
      $error("bbs_fade_pwm: unsupported parameters");
    end
  end

  logic [WIDTH-1:0] carrier_ff;
  logic [WIDTH-1:0] level_ff;
  logic [31:0] step_ff;
  logic down_ff;
  logic pwm_ff;
  wire step_done = (step_ff == 32'(STEP_CYCLES - 1));
  wire at_top = (level_ff == {WIDTH{1'b1}});
  wire at_bottom = (level_ff == '0);

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      carrier_ff <= '0;
      level_ff <= '0;
      step_ff <= 32'h0;
      down_ff <= 1'b0;
      pwm_ff <= 1'b0;
    end else if (!enable) begin
      carrier_ff <= '0;
      level_ff <= '0;
      step_ff <= 32'h0;
      down_ff <= 1'b0;
      pwm_ff <= 1'b0;
    end else begin
      carrier_ff <= carrier_ff + 1'b1;
      pwm_ff <= (carrier_ff < level_ff);
      step_ff <= step_done ? 32'h0 : step_ff + 32'h1;
      if (step_done) begin
        // Turn round at either end so brightness swings up and down
        if (down_ff && at_bottom) down_ff <= 1'b0;
        else if (!down_ff && at_top) down_ff <= 1'b1;
        else level_ff <= down_ff ? level_ff - 1'b1 : level_ff + 1'b1;
      end
    end
  end
  assign pwm_out = pwm_ff;

  off_when_idle_a: assert property (@(posedge clk) disable iff (!rst_n)
    !enable |=> !pwm_out) else $error("fade pwm active while disabled");
endmodule : bbs_fade_pwm

// ==== core/bbs_pkg.sv ====
// Package of constants for the bridge bring-up sequencer
package bbs_pkg;
  localparam int unsigned CLK_FREQ_HZ = 100000000;
  // Reset hold time the outside party must meet, in microseconds
  localparam int unsigned RESET_HOLD_US = 1000;
  localparam int unsigned RESET_HOLD_CYCLES = RESET_HOLD_US * (CLK_FREQ_HZ / 1000000);
  // SuperSpeed training timeout, in microseconds
  localparam int unsigned SS_TRAIN_TIMEOUT_US = 360000;
  localparam int unsigned SS_TRAIN_TIMEOUT_CYCLES = SS_TRAIN_TIMEOUT_US * (CLK_FREQ_HZ / 1000000);
  localparam int unsigned FADE_STEP_CYCLES = 4096;
  localparam int unsigned HEARTBEAT_CYCLES = 50000000;
  // Link power indicator codes
  localparam logic [1:0] LPI_U3 = 2'h0;
  localparam logic [1:0] LPI_U2 = 2'h1;
  localparam logic [1:0] LPI_U1 = 2'h2;
  localparam logic [1:0] LPI_U0 = 2'h3;
  localparam logic [1:0] SPEED_NONE = 2'h0;
  localparam logic [1:0] SPEED_GEN1 = 2'h1;
  localparam logic [1:0] SPEED_GEN2 = 2'h2;
  localparam logic ALT_UASP_PRIMARY = 1'b0;
  localparam logic ALT_BOT_SECONDARY = 1'b1;
  localparam int unsigned SIG_WIDTH = 32;
  typedef enum logic [3:0] {
    BBS_RESET, BBS_BOOT_LOAD, BBS_HID_WAIT, BBS_PORT_RESET, BBS_WAIT_SIG,
    BBS_IDENTIFY, BBS_DRIVE_CFG, BBS_WAIT_VBUS, BBS_SS_TRAIN, BBS_SS_UP,
    BBS_HS_UP
  } bbs_state_type;
endpackage : bbs_pkg

// ==== core/bbs_sequencer.sv ====
// Bridge bring-up sequencer: boot, SATA port bring-up, USB attach, status outputs
`timescale 1ns/1ps
module bbs_sequencer #(
  parameter int unsigned SS_TIMEOUT_CYCLES = bbs_pkg::SS_TRAIN_TIMEOUT_CYCLES,
  parameter int unsigned HEARTBEAT_CYCLES = bbs_pkg::HEARTBEAT_CYCLES,
  parameter int unsigned FADE_STEP_CYCLES = bbs_pkg::FADE_STEP_CYCLES
) (
  input wire logic clk,
  input wire logic resetn,
  input wire logic flash_present,
  input wire logic flash_image_valid,
  input wire logic flash_copy_done,
  output logic flash_copy_start,
  input wire logic hid_fw_loaded,
  output logic hid_enable,
  output logic port_reset,
  input wire logic oob_done,
  input wire logic oob_drive_found,
  input wire logic [1:0] oob_speed,
  input wire logic d2h_fis_valid,
  input wire logic [31:0] d2h_fis_sig,
  output logic [31:0] port_signature,
  output logic identify_start,
  input wire logic identify_done,
  input wire logic identify_ncq,
  output logic ncq_enable,
  output logic [1:0] sata_speed,
  input wire logic vbus_present,
  output logic ss_train_start,
  input wire logic ss_train_ok,
  output logic dp_pullup_en,
  input wire logic [1:0] ss_link_power,
  input wire logic hs_suspend,
  input wire logic set_interface_valid,
  input wire logic set_interface_alt,
  output logic bot_selected,
  input wire logic disk_activity,
  output logic heartbeat_led,
  output logic link_state_ind_bit0,
  output logic link_state_ind_bit1,
  output logic hs_suspend_led,
  output logic hs_connected_led,
  output logic ss_connected_led,
  output logic activity_pwm,
  output logic suspend_fade_pwm
);
  initial begin
    if (SS_TIMEOUT_CYCLES < 2 || HEARTBEAT_CYCLES < 2) begin
      $error("bbs_sequencer: counts too small");
    end
  end

  // ------------------------------------------------------------
  // Reset release
  // ------------------------------------------------------------
  logic rst_s1_ff;
  logic rst_n_ff;
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rst_s1_ff <= 1'b0;
      rst_n_ff <= 1'b0;
    end else begin
      rst_s1_ff <= 1'b1;
      rst_n_ff <= rst_s1_ff;
    end
  end

  // ------------------------------------------------------------
  // Bring-up state machine
  // ------------------------------------------------------------
  bbs_pkg::bbs_state_type state_ff;
  bbs_pkg::bbs_state_type nxt_state;
  logic [31:0] timer_ff;
  logic sig_seen_ff;
  wire timed_out = (timer_ff == 32'(SS_TIMEOUT_CYCLES - 1));
  wire in_boot = (state_ff == bbs_pkg::BBS_BOOT_LOAD);
  wire flash_ok = flash_present && flash_image_valid;
  wire sig_capture = (state_ff == bbs_pkg::BBS_WAIT_SIG) && d2h_fis_valid && !sig_seen_ff;
  // Attach gate: configuration done, drive detected, VBUS present
  wire attach_ok = (state_ff == bbs_pkg::BBS_WAIT_VBUS) && vbus_present;

  always_comb begin
    nxt_state = state_ff;
    unique case (state_ff)
      bbs_pkg::BBS_RESET: nxt_state = bbs_pkg::BBS_BOOT_LOAD;
      bbs_pkg::BBS_BOOT_LOAD: begin
        if (!flash_ok) nxt_state = bbs_pkg::BBS_HID_WAIT;
        else if (flash_copy_done) nxt_state = bbs_pkg::BBS_PORT_RESET;
      end
      bbs_pkg::BBS_HID_WAIT: begin
        if (hid_fw_loaded) nxt_state = bbs_pkg::BBS_PORT_RESET;
      end
      bbs_pkg::BBS_PORT_RESET: begin
        // No drive keeps the port in reset, unattached, until OOB finds a drive
        if (oob_done && oob_drive_found) nxt_state = bbs_pkg::BBS_WAIT_SIG;
      end
      bbs_pkg::BBS_WAIT_SIG: begin
        if (sig_capture) nxt_state = bbs_pkg::BBS_IDENTIFY;
      end
      bbs_pkg::BBS_IDENTIFY: begin
        if (identify_done) nxt_state = bbs_pkg::BBS_DRIVE_CFG;
      end
      bbs_pkg::BBS_DRIVE_CFG: nxt_state = bbs_pkg::BBS_WAIT_VBUS;
      bbs_pkg::BBS_WAIT_VBUS: begin
        if (attach_ok) nxt_state = bbs_pkg::BBS_SS_TRAIN;
      end
      bbs_pkg::BBS_SS_TRAIN: begin
        if (ss_train_ok) nxt_state = bbs_pkg::BBS_SS_UP;
        else if (timed_out) nxt_state = bbs_pkg::BBS_HS_UP;
      end
      bbs_pkg::BBS_SS_UP: nxt_state = bbs_pkg::BBS_SS_UP;
      bbs_pkg::BBS_HS_UP: nxt_state = bbs_pkg::BBS_HS_UP;
    endcase
    // Losing VBUS drops the link and waits for power again
    if ((state_ff == bbs_pkg::BBS_SS_TRAIN || state_ff == bbs_pkg::BBS_SS_UP ||
         state_ff == bbs_pkg::BBS_HS_UP) && !vbus_present) begin
      nxt_state = bbs_pkg::BBS_WAIT_VBUS;
    end
  end

  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      state_ff <= bbs_pkg::BBS_RESET;
      timer_ff <= 32'h0;
    end else begin
      state_ff <= nxt_state;
      timer_ff <= (state_ff == bbs_pkg::BBS_SS_TRAIN) ? timer_ff + 32'h1 : 32'h0;
    end
  end

  // ------------------------------------------------------------
  // SATA signature, speed and features
  // ------------------------------------------------------------
  logic [31:0] sig_ff;
  logic [1:0] speed_ff;
  logic ncq_ff;
  logic bot_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      sig_ff <= 32'h0;
      sig_seen_ff <= 1'b0;
      speed_ff <= bbs_pkg::SPEED_NONE;
      ncq_ff <= 1'b0;
      bot_ff <= bbs_pkg::ALT_UASP_PRIMARY;
    end else begin
      if (state_ff == bbs_pkg::BBS_PORT_RESET && oob_done && oob_drive_found) begin
        speed_ff <= oob_speed;
        sig_seen_ff <= 1'b0;
      end
      if (sig_capture) begin
        sig_ff <= d2h_fis_sig;
        sig_seen_ff <= 1'b1;
      end
      if (state_ff == bbs_pkg::BBS_IDENTIFY && identify_done) ncq_ff <= identify_ncq;
      if (state_ff != bbs_pkg::BBS_SS_UP) bot_ff <= bbs_pkg::ALT_UASP_PRIMARY;
      else if (set_interface_valid) bot_ff <= set_interface_alt;
    end
  end

  // ------------------------------------------------------------
  // Outputs and status indicators
  // ------------------------------------------------------------
  wire ss_up = (state_ff == bbs_pkg::BBS_SS_UP);
  wire hs_up = (state_ff == bbs_pkg::BBS_HS_UP);
  wire hs_susp = hs_up && hs_suspend;
  wire [1:0] lpi = ss_up ? ss_link_power : bbs_pkg::LPI_U3;
  wire fade_on = (ss_up && ss_link_power == bbs_pkg::LPI_U3) || hs_susp;

  logic [31:0] hb_cnt_ff;
  logic hb_ff;
  logic [1:0] lpi_ff;
  logic hs_susp_ff;
  logic hs_conn_ff;
  logic ss_conn_ff;
  logic act_ff;
  logic pullup_ff;
  always_ff @(posedge clk or negedge rst_n_ff) begin
    if (!rst_n_ff) begin
      hb_cnt_ff <= 32'h0;
      hb_ff <= 1'b0;
      lpi_ff <= bbs_pkg::LPI_U3;
      hs_susp_ff <= 1'b0;
      hs_conn_ff <= 1'b0;
      ss_conn_ff <= 1'b0;
      act_ff <= 1'b0;
      pullup_ff <= 1'b0;
    end else begin
      hb_cnt_ff <= (hb_cnt_ff == 32'(HEARTBEAT_CYCLES - 1)) ? 32'h0 : hb_cnt_ff + 32'h1;
      if (hb_cnt_ff == 32'(HEARTBEAT_CYCLES - 1)) hb_ff <= !hb_ff;
      lpi_ff <= lpi;
      hs_susp_ff <= hs_susp;
      hs_conn_ff <= hs_up;
      ss_conn_ff <= ss_up;
      act_ff <= disk_activity && (hs_up || ss_up);
      pullup_ff <= (nxt_state == bbs_pkg::BBS_HS_UP);
    end
  end

  bbs_fade_pwm #(
    .WIDTH(8),
    .STEP_CYCLES(FADE_STEP_CYCLES)
  ) u_fade (
    .clk(clk),
    .rst_n(rst_n_ff),
    .enable(fade_on),
    .pwm_out(suspend_fade_pwm)
  );

  assign flash_copy_start = in_boot && flash_ok;
  assign hid_enable = (state_ff == bbs_pkg::BBS_HID_WAIT);
  assign port_reset = (state_ff == bbs_pkg::BBS_PORT_RESET);
  assign identify_start = (state_ff == bbs_pkg::BBS_IDENTIFY);
  assign ss_train_start = (state_ff == bbs_pkg::BBS_SS_TRAIN);
  assign port_signature = sig_ff;
  assign ncq_enable = ncq_ff;
  assign sata_speed = speed_ff;
  assign bot_selected = bot_ff;
  assign dp_pullup_en = pullup_ff;
  assign heartbeat_led = hb_ff;
  assign link_state_ind_bit0 = lpi_ff[0];
  assign link_state_ind_bit1 = lpi_ff[1];
  assign hs_suspend_led = hs_susp_ff;
  assign hs_connected_led = hs_conn_ff;
  assign ss_connected_led = ss_conn_ff;
  assign activity_pwm = act_ff;

  sig_capture_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    sig_capture |=> port_signature == $past(d2h_fis_sig)) else $error("signature not copied");
  no_early_attach_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    $rose(ss_train_start) |-> $past(vbus_present))
    else $error("attach without vbus");
  pullup_fallback_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (ss_train_start && timed_out && !ss_train_ok && vbus_present) |=> dp_pullup_en)
    else $error("no pull-up after timeout");
  no_ss_pullup_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ss_up |=> !dp_pullup_en) else $error("pull-up at superspeed");
  lpi_code_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    !ss_up |=> {link_state_ind_bit1, link_state_ind_bit0} == bbs_pkg::LPI_U3)
    else $error("indicator not default");
  hid_fallback_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (in_boot && !flash_ok) |=> hid_enable) else $error("no hid fallback");
  bot_default_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    $rose(ss_up) |-> !bot_selected) else $error("bot default at attach");
  ncq_latch_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    (identify_start && identify_done) |=> ncq_enable == $past(identify_ncq))
    else $error("features not applied");
  reset_state_a: assert property (@(posedge clk)
    !rst_n_ff |-> !port_reset && !hid_enable && !dp_pullup_en) else $error("active in reset");
  ss_led_a: assert property (@(posedge clk) disable iff (!rst_n_ff)
    ss_up |=> ss_connected_led) else $error("ss led missing");
endmodule : bbs_sequencer

// ==== testbench/bbs_far_model.sv ====
// Far-side model: flash, SATA drive and USB host answering the sequencer
`timescale 1ns/1ps
module bbs_far_model #(
  parameter int unsigned LAT = 3,
  parameter logic [31:0] SIG_A = 32'h0000_0101,
  parameter logic [31:0] SIG_B = 32'h5a5a_0f0f
) (
  input wire logic clk,
  input wire logic has_flash,
  input wire logic has_drive,
  input wire logic fast_drive,
  input wire logic ss_capable,
  input wire logic flash_copy_start,
  input wire logic hid_enable,
  input wire logic port_reset,
  input wire logic identify_start,
  input wire logic ss_train_start,
  output logic flash_present,
  output logic flash_image_valid,
  output logic flash_copy_done,
  output logic hid_fw_loaded,
  output logic oob_done,
  output logic oob_drive_found,
  output logic [1:0] oob_speed,
  output logic d2h_fis_valid,
  output logic [31:0] d2h_fis_sig,
  output logic identify_done,
  output logic identify_ncq,
  output logic ss_train_ok
);
  logic [7:0] cnt_ff = 8'h00;
  logic [5:0] fis_ff = 6'h00;
  wire act = flash_copy_start | hid_enable | port_reset | identify_start | ss_train_start;
  wire hit = act && (cnt_ff == LAT[7:0]);
  assign flash_present = has_flash;
  assign flash_image_valid = has_flash;
  initial begin
    {flash_copy_done, hid_fw_loaded, oob_done, oob_drive_found, oob_speed} = 6'h00;
    {d2h_fis_valid, identify_done, identify_ncq, ss_train_ok} = 4'h0;
    d2h_fis_sig = 32'h0000_0000;
  end
  // Commands answered when the shared count reaches LAT (training only with ss_capable); port reset after boot or HID starts at 1, so is one cycle sooner
  always @(posedge clk) begin
    cnt_ff <= (act && !hit) ? cnt_ff + 8'h01 : 8'h00;
    flash_copy_done <= flash_copy_start && hit;
    hid_fw_loaded <= hid_enable && hit;
    oob_done <= port_reset && hit;
    oob_drive_found <= port_reset && hit && has_drive;
    oob_speed <= (port_reset && hit && has_drive) ? (fast_drive ? 2'h2 : 2'h1) : 2'h0;
    // Two signature frames: only the first may be kept
    fis_ff <= {fis_ff[4:0], oob_done & oob_drive_found};
    d2h_fis_valid <= fis_ff[2] | fis_ff[5];
    d2h_fis_sig <= fis_ff[2] ? SIG_A : (fis_ff[5] ? SIG_B : ~d2h_fis_sig);
    identify_done <= identify_start && hit;
    identify_ncq <= identify_start && hit && fast_drive;
    ss_train_ok <= ss_capable && (ss_train_ok || (ss_train_start && hit));
  end
endmodule : bbs_far_model

// ==== testbench/bbs_sequencer_tb.sv ====
// Self-checking bench for the bridge bring-up sequencer
`timescale 1ns/1ps
module bbs_sequencer_tb;
  logic clk = 1'b0, resetn = 1'b0, vbus_present = 1'b0, hs_suspend = 1'b0;
  logic set_interface_valid = 1'b0, set_interface_alt = 1'b0, disk_activity = 1'b0;
  logic [1:0] ss_link_power = 2'h3;
  logic has_flash = 1'b1, has_drive = 1'b1, fast_drive = 1'b1, ss_capable = 1'b1;
  logic flash_present, flash_image_valid, flash_copy_done, flash_copy_start, hid_fw_loaded;
  logic hid_enable, port_reset, oob_done, oob_drive_found, d2h_fis_valid, identify_start;
  logic identify_done, identify_ncq, ncq_enable, ss_train_start, ss_train_ok, dp_pullup_en;
  logic bot_selected, heartbeat_led, link_state_ind_bit0, link_state_ind_bit1;
  logic hs_suspend_led, hs_connected_led, ss_connected_led, activity_pwm, suspend_fade_pwm;
  logic [1:0] oob_speed, sata_speed;
  logic [31:0] d2h_fis_sig, port_signature;
  wire logic [11:0] mon = {ncq_enable, hs_suspend_led, suspend_fade_pwm, heartbeat_led,
    hs_connected_led, ss_connected_led, dp_pullup_en, ss_train_start, identify_start,
    port_reset, hid_enable, flash_copy_start};
  int bad_count = 0;
  int comparisons = 0;

  initial begin
    forever #5 clk = ~clk;
  end

  bbs_sequencer #(.SS_TIMEOUT_CYCLES(50), .HEARTBEAT_CYCLES(20), .FADE_STEP_CYCLES(2)) i_dut (
    .clk, .resetn, .flash_present, .flash_image_valid, .flash_copy_done, .flash_copy_start,
    .hid_fw_loaded, .hid_enable, .port_reset, .oob_done, .oob_drive_found, .oob_speed,
    .d2h_fis_valid, .d2h_fis_sig, .port_signature, .identify_start, .identify_done,
    .identify_ncq, .ncq_enable, .sata_speed, .vbus_present, .ss_train_start, .ss_train_ok,
    .dp_pullup_en, .ss_link_power, .hs_suspend, .set_interface_valid, .set_interface_alt,
    .bot_selected, .disk_activity, .heartbeat_led, .link_state_ind_bit0, .link_state_ind_bit1,
    .hs_suspend_led, .hs_connected_led, .ss_connected_led, .activity_pwm, .suspend_fade_pwm);

  bbs_far_model i_far (
    .clk, .has_flash, .has_drive, .fast_drive, .ss_capable, .flash_copy_start, .hid_enable,
    .port_reset, .identify_start, .ss_train_start, .flash_present, .flash_image_valid,
    .flash_copy_done, .hid_fw_loaded, .oob_done, .oob_drive_found, .oob_speed,
    .d2h_fis_valid, .d2h_fis_sig, .identify_done, .identify_ncq, .ss_train_ok);

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  task automatic summarize();
    $display("comparisons %0d, mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : summarize

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk

  task automatic wait_bit(input int b, input int lim);
    int n;
    n = 0;
    while (mon[b] !== 1'b1 && n < lim) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (mon[b] !== 1'b1) begin
      bad_count++;
      $display("ERROR at %0t: wait on monitor bit %0d ran out", $time, b);
      summarize();
    end
  endtask : wait_bit

  task automatic count_hi(input int b, input int cyc, output int hi);
    hi = 0;
    repeat (cyc) begin
      @(posedge clk);
      #1;
      if (mon[b] === 1'b1) hi++;
    end
  endtask : count_hi

  task automatic do_reset(input logic fl, input logic dr, input logic fa, input logic ss);
    @(posedge clk);
    resetn <= 1'b0;
    {has_flash, has_drive, fast_drive, ss_capable} <= {fl, dr, fa, ss};
    {vbus_present, hs_suspend, disk_activity} <= 3'h0;
    ss_link_power <= 2'h3;
    repeat (6) @(posedge clk);
    #1;
    chk({mon[10:0], activity_pwm, link_state_ind_bit1, link_state_ind_bit0, sata_speed,
      bot_selected, port_signature != 32'h0}, 32'h0, "outputs in reset");
    @(posedge clk);
    resetn <= 1'b1;
    repeat (3) @(posedge clk);
  endtask : do_reset

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic t_superspeed();
    int hi;
    do_reset(1'b1, 1'b1, 1'b1, 1'b1);
    wait_bit(0, 20);
    wait_bit(2, 50);
    wait_bit(3, 50);
    chk(sata_speed, bbs_pkg::SPEED_GEN2, "speed");
    chk(port_signature, i_far.SIG_A, "signature");
    wait_bit(11, 50);
    repeat (12) @(posedge clk);
    chk(port_signature, i_far.SIG_A, "second frame kept out");
    chk(ss_train_start, 1'b0, "attach before vbus");
    vbus_present <= 1'b1;
    wait_bit(4, 20);
    wait_bit(6, 20);
    chk({dp_pullup_en, hs_connected_led}, 2'h0, "no usb2 fallback");
    for (int p = 0; p < 4; p++) begin
      @(posedge clk);
      ss_link_power <= p[1:0];
      repeat (2) @(posedge clk);
      #1;
      chk({link_state_ind_bit1, link_state_ind_bit0}, p, "link indicator");
    end
    chk(bot_selected, bbs_pkg::ALT_UASP_PRIMARY, "default interface");
    @(posedge clk);
    {set_interface_valid, set_interface_alt} <= 2'h3;
    @(posedge clk);
    set_interface_valid <= 1'b0;
    repeat (3) @(posedge clk);
    chk(bot_selected, bbs_pkg::ALT_BOT_SECONDARY, "bot selected");
    disk_activity <= 1'b1;
    @(posedge clk);
    #1;
    chk(activity_pwm, 1'b1, "activity on");
    @(posedge clk);
    disk_activity <= 1'b0;
    @(posedge clk);
    #1;
    chk(activity_pwm, 1'b0, "activity off");
    @(posedge clk);
    ss_link_power <= 2'h0;
    count_hi(9, 600, hi);
    chk(hi > 0 && hi < 600, 1'b1, "fade in u3");
    @(posedge clk);
    ss_link_power <= 2'h3;
    repeat (5) @(posedge clk);
    count_hi(9, 300, hi);
    chk(hi, 0, "fade in u0");
    count_hi(8, 100, hi);
    chk(hi > 20 && hi < 80, 1'b1, "heartbeat");
    // Losing bus power must drop the link and go back to waiting
    @(posedge clk);
    vbus_present <= 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk({ss_connected_led, ss_train_start, hs_connected_led}, 3'h0, "vbus lost");
    $display("done: superspeed bring-up");
  endtask : t_superspeed

  task automatic t_host_load_hs();
    int hi;
    do_reset(1'b0, 1'b1, 1'b0, 1'b0);
    wait_bit(1, 20);
    chk(flash_copy_start, 1'b0, "no flash copy");
    wait_bit(2, 50);
    wait_bit(3, 50);
    chk(sata_speed, bbs_pkg::SPEED_GEN1, "speed");
    @(posedge clk);
    vbus_present <= 1'b1;
    wait_bit(4, 50);
    chk(dp_pullup_en, 1'b0, "pull-up during training");
    chk(ncq_enable, 1'b0, "no queuing feature");
    wait_bit(5, 100);
    wait_bit(7, 20);
    chk({ss_connected_led, link_state_ind_bit1, link_state_ind_bit0}, 3'h0, "hs leds");
    @(posedge clk);
    {set_interface_valid, set_interface_alt} <= 2'h3;
    @(posedge clk);
    set_interface_valid <= 1'b0;
    hs_suspend <= 1'b1;
    repeat (3) @(posedge clk);
    chk({bot_selected, hs_suspend_led}, 2'h1, "hs suspend");
    count_hi(9, 600, hi);
    chk(hi > 0 && hi < 600, 1'b1, "fade in suspend");
    $display("done: host load and usb2 fallback");
  endtask : t_host_load_hs

  task automatic t_no_drive();
    do_reset(1'b1, 1'b0, 1'b1, 1'b1);
    vbus_present <= 1'b1;
    wait_bit(2, 50);
    repeat (40) @(posedge clk);
    #1;
    chk({port_reset, identify_start, ss_train_start}, 3'h4, "no drive");
    $display("done: no drive attached");
  endtask : t_no_drive

  initial begin
    t_superspeed();
    t_host_load_hs();
    t_no_drive();
    summarize();
  end
endmodule : bbs_sequencer_tb
